// ==== core/dma_pkg.sv ====
// constants, field layouts and state names shared by both ends of the link
// assumes a single 25 MHz clock domain and a 32-bit system bus
package dma_pkg;
  // ==========================================================
  // sizes
  localparam int          NCH           = 32;          // channels
  localparam int          CHW           = 5;           // channel index width
  localparam int          AW            = 8;           // register port address width
  // ==========================================================
  // register offsets on the software port
  localparam logic [7:0]  REG_PRIO_SET  = 8'h00;       // channel_priority_set_reg
  localparam logic [7:0]  REG_PRIO_CLR  = 8'h04;       // channel_priority_clear_reg
  localparam logic [7:0]  REG_BURST_SET = 8'h08;       // burst_only_set_reg
  localparam logic [7:0]  REG_BURST_CLR = 8'h0C;       // burst-only clear
  localparam logic [7:0]  REG_ENA_SET   = 8'h10;       // channel_enable_set_reg
  localparam logic [7:0]  REG_ENA_CLR   = 8'h14;       // channel_enable_clear_reg
  localparam logic [7:0]  REG_BASE      = 8'h18;       // control table base
  localparam logic [7:0]  REG_ALT       = 8'h1C;       // alternate structure select
  localparam logic [7:0]  REG_STATUS    = 8'h20;       // engine status
  localparam logic [31:0] RST_WORD      = 32'h0000_0000; // reset value of all 32-bit registers
  // ==========================================================
  // control table layout
  localparam int          TABLE_ALIGN   = 10;          // base on 1024-byte boundary
  localparam logic [3:0]  SRC_END_OFF   = 4'h0;        // source end pointer
  localparam logic [3:0]  DST_END_OFF   = 4'h4;        // destination end pointer
  localparam logic [3:0]  CTL_OFF       = 4'h8;        // control word, 0xC is unused
  // ==========================================================
  // control word fields
  localparam int          CTL_MODE_LSB  = 0;           // transfer mode, 3 bits
  localparam int          CTL_BURST_BIT = 3;           // burst-only flag
  localparam int          CTL_CNT_LSB   = 4;           // items minus one, 10 bits
  localparam int          CTL_ARB_LSB   = 14;          // log2 arbitration size, 4 bits
  localparam int          CTL_SSIZE_LSB = 24;          // source data size
  localparam int          CTL_SINC_LSB  = 26;          // source increment
  localparam int          CTL_DSIZE_LSB = 28;          // destination data size
  localparam int          CTL_DINC_LSB  = 30;          // destination increment
  localparam logic [2:0]  MODE_STOP     = 3'h0;        // stopped
  localparam logic [1:0]  INC_NONE      = 2'h3;        // no address increment
  localparam logic [1:0]  SIZE_WORD     = 2'h2;        // 32-bit access
  localparam logic [3:0]  ARB_LOG_MAX   = 4'hA;        // 1024 items
  // ==========================================================
  // engine states
  typedef enum logic [2:0] {ST_IDLE, ST_FSRC, ST_FDST, ST_FCTL, ST_DECIDE, ST_RD, ST_WR, ST_WB} eng_state_type;
endpackage

// ==== core/dma_link_if.sv ====
// link between the dma engine and the system side (peripheral requests, shared bus)
// assumes both ends run on the same clock; no clocking block
`timescale 1ns/1ps
interface dma_link_if;
  // ==========================================================
  // peripheral requests and completion
  logic [31:0] single_req;  // per-channel single request, level
  logic [31:0] burst_req;   // per-channel burst request, level
  logic [31:0] done;        // per-channel transfer complete, one-cycle pulse
  // ==========================================================
  // engine bus access
  logic        mem_req;     // access wanted, held until mem_ack
  logic        mem_we;      // write when high
  logic [31:0] mem_addr;    // byte address
  logic [31:0] mem_wdata;   // write data
  logic [1:0]  mem_size;    // 0 byte, 1 half, 2 word
  logic [31:0] mem_rdata;   // read data, valid with mem_ack
  logic        mem_ack;     // access done, one-cycle pulse

  modport engine (input single_req, burst_req, mem_rdata, mem_ack,
                  output done, mem_req, mem_we, mem_addr, mem_wdata, mem_size);
  modport system (output single_req, burst_req, mem_rdata, mem_ack,
                  input done, mem_req, mem_we, mem_addr, mem_wdata, mem_size);
endinterface

// ==== core/dma_system_end.sv ====
// system side of the dma link: peripheral request registers and the shared bus
// owner, on which the processor always wins over the engine
// assumes CPU_BUSY and the SYS_* answer come from logic on the same clock
`timescale 1ns/1ps
module dma_system_end (
  // clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RST,
  // engine link
  dma_link_if.system                 link,
  // peripheral side
  input  wire logic [dma_pkg::NCH-1:0] PERIPH_SINGLE,
  input  wire logic [dma_pkg::NCH-1:0] PERIPH_BURST,
  output logic      [dma_pkg::NCH-1:0] PERIPH_DONE,
  // shared system bus
  input  wire logic                  CPU_BUSY,
  output logic                       SYS_REQ,
  output logic                       SYS_WE,
  output logic      [31:0]           SYS_ADDR,
  output logic      [31:0]           SYS_WDATA,
  output logic      [1:0]            SYS_SIZE,
  input  wire logic [31:0]           SYS_RDATA,
  input  wire logic                  SYS_ACK
);
  import dma_pkg::*;

  logic          pend_r;     // bus access issued, answer awaited
  logic          ack_r;      // answer to the engine
  logic [31:0]   rdata_r;    // read data to the engine
  logic [NCH-1:0] single_r;  // registered single requests
  logic [NCH-1:0] burst_r;   // registered burst requests
  wire           start;      // engine access may go out now

  // the processor holds the bus off; no new access in the answer cycle
  assign start = link.mem_req && !CPU_BUSY && !pend_r && !ack_r;

  assign link.single_req = single_r;
  assign link.burst_req  = burst_r;
  assign link.mem_ack    = ack_r;
  assign link.mem_rdata  = rdata_r;

  // ==========================================================
  // request and completion registers
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      single_r    <= RST_WORD;
      burst_r     <= RST_WORD;
      PERIPH_DONE <= RST_WORD;
    end else begin
      single_r    <= PERIPH_SINGLE;
      burst_r     <= PERIPH_BURST;
      PERIPH_DONE <= link.done;
    end
  end

  // ==========================================================
  // bus issue: one strobe cycle, then wait for the answer
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      pend_r    <= 1'b0;
      ack_r     <= 1'b0;
      rdata_r   <= RST_WORD;
      SYS_REQ   <= 1'b0;
      SYS_WE    <= 1'b0;
      SYS_ADDR  <= RST_WORD;
      SYS_WDATA <= RST_WORD;
      SYS_SIZE  <= SIZE_WORD;
    end else begin
      SYS_REQ <= start;
      ack_r   <= 1'b0;
      if (start) begin
        // latch the access
        pend_r    <= 1'b1;
        SYS_WE    <= link.mem_we;
        SYS_ADDR  <= link.mem_addr;
        SYS_WDATA <= link.mem_wdata;
        SYS_SIZE  <= link.mem_size;
      end else if (pend_r && SYS_ACK) begin
        // hand the answer back
        pend_r  <= 1'b0;
        ack_r   <= 1'b1;
        rdata_r <= SYS_RDATA;
      end
    end
  end
endmodule

// ==== core/dma_engine_end.sv ====
// dma engine end: channel arbitration, control table fetch, item moves,
// control word write-back and channel enable handling
// assumes the system end answers every bus access with one mem_ack pulse
// Behaviour
// - equal level: lower channel number wins
// - high-priority bit beats all default channels
// - high channels ordered by number too
// - priority bit via set and clear registers
// - grant highest-priority requesting channel
// - rearbitrate after arbitration-size items moved
// - started burst finishes before new arbitration
// - processor wins bus; engine stalls, resumes
// - single and burst requests on every channel
// - both requests asserted: treat as burst
// - single request moves exactly one item
// - burst moves min(arbitration size, remaining)
// - burst-only bit ignores single requests
// - table base aligned on 1024 bytes
// - primary at n*0x10, alternate from 0x200
// - structure: source, destination, control, unused
// - end pointers inclusive; fixed side fixed
// - decode sizes, increments, counts, flag, mode
// - write back count and mode; stop at end
// - end pointers never written by engine
// - enable set/clear; auto-disable on completion
// - software rewrites control word each transfer
// - stop mode: no transfer, disable channel
`timescale 1ns/1ps
module dma_engine_end (
  // clock and reset
  input  wire logic                 CLOCK,
  input  wire logic                 RST,
  // link to the system end
  dma_link_if.engine                link,
  // software register port
  input  wire logic [dma_pkg::AW-1:0] REG_ADDR,
  input  wire logic [31:0]          REG_WDATA,
  input  wire logic                 REG_WE,
  input  wire logic                 REG_RE,
  output logic      [31:0]          REG_RDATA
);
  import dma_pkg::*;

  // ==========================================================
  // helpers
  // lowest-numbered channel of the high pool, else of all requests
  function automatic logic [CHW-1:0] pick(input logic [NCH-1:0] elig, input logic [NCH-1:0] prio);
    logic [NCH-1:0] pool;
    pick = '0;
    pool = (|(elig & prio)) ? (elig & prio) : elig;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (pool[i]) begin
        pick = i[CHW-1:0];
      end
    end
  endfunction

  // structure word address inside the table
  function automatic logic [31:0] struct_addr(input logic [31:0] base, input logic alt,
                                              input logic [CHW-1:0] ch, input logic [3:0] off);
    struct_addr = {base[31:TABLE_ALIGN], alt, ch, off};
  endfunction

  // address of the next item counted back from the inclusive end pointer
  function automatic logic [31:0] item_addr(input logic [31:0] end_p, input logic [1:0] inc,
                                            input logic [10:0] left);
    logic [31:0] span;
    span = {21'h0_0000, left - 11'h001} << inc;
    item_addr = (inc == INC_NONE) ? end_p : end_p - span;
  endfunction

  // ==========================================================
  // state
  eng_state_type   state_r;      // engine sequence
  logic [NCH-1:0]  prio_r;       // high-priority bits
  logic [NCH-1:0]  bonly_r;      // burst-only bits
  logic [NCH-1:0]  ena_r;        // channel enables
  logic [NCH-1:0]  alt_r;        // use alternate structure
  logic [31:0]     base_r;       // table base, low bits held zero
  logic [CHW-1:0]  chan_r;       // channel in service
  logic [31:0]     src_end_r;    // source end pointer
  logic [31:0]     dst_end_r;    // destination end pointer
  logic [31:0]     ctl_r;        // control word as fetched
  logic [10:0]     left_r;       // items remaining in the transfer
  logic [10:0]     run_r;        // items remaining in this burst
  logic [NCH-1:0]  done_r;       // completion pulses
  logic            req_r;        // bus access wanted
  logic            we_r;         // bus write
  logic [31:0]     addr_r;       // bus address
  logic [31:0]     wdata_r;      // bus write data
  logic [1:0]      size_r;       // bus access size

  // ==========================================================
  // request qualification and grant
  wire [NCH-1:0]   elig;         // channels that may be granted
  wire [CHW-1:0]   winner;       // granted channel
  wire [CHW-1:0]   ch_in;        // channel in service, taken from chan_r
  assign elig   = ena_r & (link.burst_req | (link.single_req & ~bonly_r));
  assign winner = pick(elig, prio_r);
  assign ch_in  = chan_r;

  // ==========================================================
  // control word decode
  wire [2:0]       f_mode;       // transfer mode
  wire             f_bonly;      // burst-only flag
  wire [10:0]      f_left;       // items in the transfer, 1..1024
  wire [3:0]       f_arb;        // log2 arbitration size
  wire [10:0]      arb_size;     // arbitration size, 1..1024
  wire [10:0]      run_len;      // items granted this time
  wire [1:0]       s_size;       // source data size
  wire [1:0]       s_inc;        // source increment
  wire [1:0]       d_size;       // destination data size
  wire [1:0]       d_inc;        // destination increment
  wire             is_burst;     // burst wins when both present
  assign f_mode   = ctl_r[CTL_MODE_LSB +: 3];
  assign f_bonly  = ctl_r[CTL_BURST_BIT];
  assign f_left   = {1'b0, ctl_r[CTL_CNT_LSB +: 10]} + 11'h001;
  assign f_arb    = ctl_r[CTL_ARB_LSB +: 4];
  assign s_size   = ctl_r[CTL_SSIZE_LSB +: 2];
  assign s_inc    = ctl_r[CTL_SINC_LSB +: 2];
  assign d_size   = ctl_r[CTL_DSIZE_LSB +: 2];
  assign d_inc    = ctl_r[CTL_DINC_LSB +: 2];
  assign arb_size = (f_arb > ARB_LOG_MAX) ? (11'h001 << ARB_LOG_MAX) : (11'h001 << f_arb);
  assign is_burst = link.burst_req[chan_r];
  assign run_len  = !is_burst ? 11'h001 : ((arb_size < f_left) ? arb_size : f_left);

  // ==========================================================
  // move bookkeeping
  wire             ack;          // bus answer
  wire [10:0]      left_dec;     // remaining after this item
  wire             last_run;     // burst ends with this item
  wire [31:0]      ctl_back;     // control word to write back
  wire             stop_hit;     // stop mode seen after fetch
  wire             fin_hit;      // transfer completed
  wire [NCH-1:0]   chan_hot;     // one-hot of the channel in service
  wire [NCH-1:0]   ena_hw_clr;   // enable bits the engine drops
  assign ack      = link.mem_ack;
  assign left_dec = left_r - 11'h001;
  assign last_run = (run_r == 11'h001);
  assign ctl_back = (left_dec == 11'h000) ?
                    {ctl_r[31:CTL_CNT_LSB+10], 10'h000, ctl_r[CTL_CNT_LSB-1:3], MODE_STOP} :
                    {ctl_r[31:CTL_CNT_LSB+10], left_dec[9:0] - 10'h001, ctl_r[CTL_CNT_LSB-1:0]};
  assign stop_hit = (state_r == ST_DECIDE) && (f_mode == MODE_STOP);
  assign fin_hit  = (state_r == ST_WB) && ack && (left_r == 11'h000);
  assign chan_hot = {{(NCH-1){1'b0}}, 1'b1} << ch_in;
  assign ena_hw_clr = (stop_hit || fin_hit) ? chan_hot : '0;

  // ==========================================================
  // software register decode
  wire [NCH-1:0]   w_prio_set;   // masks written this cycle
  wire [NCH-1:0]   w_prio_clr;
  wire [NCH-1:0]   w_bo_set;
  wire [NCH-1:0]   w_bo_clr;
  wire [NCH-1:0]   w_ena_set;
  wire [NCH-1:0]   w_ena_clr;
  wire [31:0]      rd_mux;       // read selection
  assign w_prio_set = (REG_WE && REG_ADDR == REG_PRIO_SET)  ? REG_WDATA : '0;
  assign w_prio_clr = (REG_WE && REG_ADDR == REG_PRIO_CLR)  ? REG_WDATA : '0;
  assign w_bo_set   = (REG_WE && REG_ADDR == REG_BURST_SET) ? REG_WDATA : '0;
  assign w_bo_clr   = (REG_WE && REG_ADDR == REG_BURST_CLR) ? REG_WDATA : '0;
  assign w_ena_set  = (REG_WE && REG_ADDR == REG_ENA_SET)   ? REG_WDATA : '0;
  assign w_ena_clr  = (REG_WE && REG_ADDR == REG_ENA_CLR)   ? REG_WDATA : '0;
  assign rd_mux = (REG_ADDR == REG_PRIO_SET || REG_ADDR == REG_PRIO_CLR) ? prio_r :
                  (REG_ADDR == REG_BURST_SET || REG_ADDR == REG_BURST_CLR) ? bonly_r :
                  (REG_ADDR == REG_ENA_SET || REG_ADDR == REG_ENA_CLR) ? ena_r :
                  (REG_ADDR == REG_BASE) ? base_r :
                  (REG_ADDR == REG_ALT) ? alt_r :
                  (REG_ADDR == REG_STATUS) ? {26'h000_0000, state_r != ST_IDLE, chan_r} :
                  RST_WORD;

  // ==========================================================
  // link outputs straight from flops
  assign link.done      = done_r;
  assign link.mem_req   = req_r;
  assign link.mem_we    = we_r;
  assign link.mem_addr  = addr_r;
  assign link.mem_wdata = wdata_r;
  assign link.mem_size  = size_r;

  // ==========================================================
  // software registers; a software set wins over an engine clear
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      prio_r    <= RST_WORD;
      bonly_r   <= RST_WORD;
      ena_r     <= RST_WORD;
      alt_r     <= RST_WORD;
      base_r    <= RST_WORD;
      REG_RDATA <= RST_WORD;
    end else begin
      prio_r  <= (prio_r & ~w_prio_clr) | w_prio_set;
      bonly_r <= (bonly_r & ~w_bo_clr) | w_bo_set;
      ena_r   <= (ena_r & ~w_ena_clr & ~ena_hw_clr) | w_ena_set;
      if (REG_WE && REG_ADDR == REG_ALT) begin
        alt_r <= REG_WDATA;
      end
      if (REG_WE && REG_ADDR == REG_BASE) begin
        // low address bits forced to zero keep the table aligned
        base_r <= {REG_WDATA[31:TABLE_ALIGN], {TABLE_ALIGN{1'b0}}};
      end
      // read data stands in the cycle after the strobe only
      REG_RDATA <= REG_RE ? rd_mux : RST_WORD;
    end
  end

  // ==========================================================
  // engine sequence: fetch structure, move items, write control word
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_r   <= ST_IDLE;
      chan_r    <= '0;
      src_end_r <= RST_WORD;
      dst_end_r <= RST_WORD;
      ctl_r     <= RST_WORD;
      left_r    <= '0;
      run_r     <= '0;
      done_r    <= RST_WORD;
      req_r     <= 1'b0;
      we_r      <= 1'b0;
      addr_r    <= RST_WORD;
      wdata_r   <= RST_WORD;
      size_r    <= SIZE_WORD;
    end else begin
      done_r <= '0;
      case (state_r)
        ST_IDLE: begin
          if (|elig) begin
            // arbitrate only here, never inside a burst
            chan_r  <= winner;
            req_r   <= 1'b1;
            we_r    <= 1'b0;
            size_r  <= SIZE_WORD;
            addr_r  <= struct_addr(base_r, alt_r[winner], winner, SRC_END_OFF);
            state_r <= ST_FSRC;
          end
        end
        ST_FSRC: begin
          if (ack) begin
            src_end_r <= link.mem_rdata;
            addr_r    <= struct_addr(base_r, alt_r[chan_r], chan_r, DST_END_OFF);
            state_r   <= ST_FDST;
          end
        end
        ST_FDST: begin
          if (ack) begin
            dst_end_r <= link.mem_rdata;
            addr_r    <= struct_addr(base_r, alt_r[chan_r], chan_r, CTL_OFF);
            state_r   <= ST_FCTL;
          end
        end
        ST_FCTL: begin
          if (ack) begin
            ctl_r   <= link.mem_rdata;
            req_r   <= 1'b0;
            state_r <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          if (f_mode == MODE_STOP) begin
            // nothing to move; the enable drops through ena_hw_clr
            state_r <= ST_IDLE;
          end else if ((f_bonly || bonly_r[chan_r]) && !is_burst) begin
            // single request on a burst-only channel is ignored
            state_r <= ST_IDLE;
          end else begin
            left_r  <= f_left;
            run_r   <= run_len;
            req_r   <= 1'b1;
            size_r  <= s_size;
            addr_r  <= item_addr(src_end_r, s_inc, f_left);
            state_r <= ST_RD;
          end
        end
        ST_RD: begin
          if (ack) begin
            we_r    <= 1'b1;
            wdata_r <= link.mem_rdata;
            size_r  <= d_size;
            addr_r  <= item_addr(dst_end_r, d_inc, left_r);
            state_r <= ST_WR;
          end
        end
        ST_WR: begin
          if (ack) begin
            left_r <= left_dec;
            run_r  <= run_r - 11'h001;
            if (last_run || left_dec == 11'h000) begin
              // only the control word goes back, never the end pointers
              wdata_r <= ctl_back;
              size_r  <= SIZE_WORD;
              addr_r  <= struct_addr(base_r, alt_r[chan_r], chan_r, CTL_OFF);
              state_r <= ST_WB;
            end else begin
              // burst goes on without looking at other requests
              we_r    <= 1'b0;
              size_r  <= s_size;
              addr_r  <= item_addr(src_end_r, s_inc, left_dec);
              state_r <= ST_RD;
            end
          end
        end
        ST_WB: begin
          if (ack) begin
            req_r   <= 1'b0;
            we_r    <= 1'b0;
            done_r  <= (left_r == 11'h000) ? chan_hot : '0;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

// ==== tb/dma_link_props.sv ====
// checker for the engine/system link: handshake holds and completion write-back
// assumes one clock; instantiated once beside the link interface
`timescale 1ns/1ps
module dma_link_props (
  // clock and reset
  input wire logic        CLOCK,
  input wire logic        RST,
  // watched link signals
  input wire logic [31:0] done,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic        mem_ack
);
  import dma_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // ==========================================================
  // bus access holds through processor stalls
  chk_req_held: assert property (mem_req && !mem_ack |=> mem_req)
    else $error("access dropped before its answer");
  chk_addr_hold: assert property (mem_req && !mem_ack |=> $stable(mem_addr) && $stable(mem_we))
    else $error("access address moved while waiting");
  chk_wdata_hold: assert property (mem_req && mem_we && !mem_ack |=> $stable(mem_wdata))
    else $error("write data moved while waiting");
  chk_ack_in_req: assert property (mem_ack |-> mem_req)
    else $error("answer without a pending access");
  chk_ack_pulse: assert property (mem_ack |=> !mem_ack)
    else $error("answer longer than one cycle");
  // ==========================================================
  // completion: one channel, one pulse, after the stop write-back
  chk_done_onehot: assert property ($onehot0(done))
    else $error("several channels completed at once");
  chk_done_pulse: assert property (|done |=> done == 32'h0000_0000)
    else $error("completion longer than one cycle");
  chk_done_after_wb: assert property (|done |-> $past(mem_ack) && $past(mem_we))
    else $error("completion not after a write-back");
  chk_wb_stop: assert property (|done |-> $past(mem_wdata[2:0]) == MODE_STOP && $past(mem_wdata[13:4]) == 10'h0)
    else $error("final write-back not stopped with zero count");
  // main scenarios
  cover property (|done);
  cover property ((mem_req && !mem_ack) [*3]);
  cover property (mem_ack && mem_we);
endmodule

// ==== tb/multichannel_dma_arbiter_tb_top.sv ====
// top bench: both link ends, a memory with a busy processor, register tests
// assumes control table at 0x1000, fixed destination 0x3000
`timescale 1ns/1ps
module multichannel_dma_arbiter_tb_top;
  import dma_pkg::*;
  logic CLOCK = 0, RST = 1, REG_WE = 0, REG_RE = 0, CPU_BUSY = 0, SYS_ACK = 0, pend = 0;
  logic [7:0]  REG_ADDR = 8'h00;
  logic [31:0] REG_WDATA = 0, PERIPH_SINGLE = 0, PERIPH_BURST = 0, SYS_RDATA = 0, d;
  logic [31:0] REG_RDATA, PERIPH_DONE, SYS_ADDR, SYS_WDATA;
  logic        SYS_REQ, SYS_WE;
  logic [1:0]  SYS_SIZE;
  logic [31:0] mem [logic [31:0]];
  int          n_mismatch = 0, samples_checked = 0, nwr = 0, cyc = 0, ndone = 0;
  dma_link_if link ();
  dma_engine_end dma_engine_end_i (.CLOCK(CLOCK), .RST(RST), .link(link.engine), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA));
  dma_system_end dma_system_end_i (.CLOCK(CLOCK), .RST(RST), .link(link.system), .PERIPH_SINGLE(PERIPH_SINGLE),
    .PERIPH_BURST(PERIPH_BURST), .PERIPH_DONE(PERIPH_DONE), .CPU_BUSY(CPU_BUSY), .SYS_REQ(SYS_REQ),
    .SYS_WE(SYS_WE), .SYS_ADDR(SYS_ADDR), .SYS_WDATA(SYS_WDATA), .SYS_SIZE(SYS_SIZE),
    .SYS_RDATA(SYS_RDATA), .SYS_ACK(SYS_ACK));
  dma_link_props dma_link_props_i (.CLOCK(CLOCK), .RST(RST), .done(link.done), .mem_req(link.mem_req),
    .mem_we(link.mem_we), .mem_addr(link.mem_addr), .mem_wdata(link.mem_wdata), .mem_ack(link.mem_ack));
  always #20 CLOCK = ~CLOCK;
  // memory answering one cycle late; processor takes the bus 2 cycles in 7
  always @(posedge CLOCK) begin
    cyc++;
    CPU_BUSY <= (cyc % 7) < 2;
    SYS_ACK <= 1'b0;
    SYS_RDATA <= ~SYS_RDATA;
    if (PERIPH_DONE[9]) ndone++;
    if (SYS_REQ) pend <= 1'b1;
    else if (pend) begin
      SYS_ACK <= 1'b1; pend <= 1'b0;
      SYS_RDATA <= mem.exists(SYS_ADDR) ? mem[SYS_ADDR] : 32'h0000_0000;
      if (SYS_WE) mem[SYS_ADDR] = SYS_WDATA;
      if (SYS_WE && SYS_ADDR == 32'h0000_3000) nwr++;
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++; $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    REG_ADDR <= a; REG_WDATA <= v; REG_WE <= 1'b1;
    @(posedge CLOCK); REG_WE <= 1'b0;
    @(posedge CLOCK);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    REG_ADDR <= a; REG_RE <= 1'b1;
    @(posedge CLOCK); REG_RE <= 1'b0;
    @(posedge CLOCK); v = REG_RDATA;
  endtask
  // poll a register until the masked bits fall
  task automatic poll(input logic [7:0] a, input logic [31:0] m);
    d = m;
    for (int i = 0; i < 300 && (d & m) != 0; i++) rd(a, d);
  endtask
  // structure of one channel: word source ending at its data, fixed destination
  task automatic arm(input int ch, input int n, input int arb, input int md);
    mem[32'h2000 + ch * 4] = 32'hA000 + ch;
    mem[32'h1000 + ch * 16] = 32'h2000 + ch * 4;
    mem[32'h1004 + ch * 16] = 32'h0000_3000;
    mem[32'h1008 + ch * 16] = {INC_NONE, SIZE_WORD, 2'h2, SIZE_WORD, 6'h0, 4'(arb), 10'(n - 1), 1'b0, 3'(md)};
    wr(REG_ENA_SET, 32'h1 << ch);
  endtask
  // two channels ask at once; the data left at the destination is the later one's
  task automatic race(input int a, input int b, input logic [31:0] pri, input int last);
    arm(a, 1, 0, 1); arm(b, 1, 0, 1);
    wr(REG_PRIO_SET, pri);
    PERIPH_BURST <= (32'h1 << a) | (32'h1 << b);
    poll(REG_ENA_SET, (32'h1 << a) | (32'h1 << b));
    PERIPH_BURST <= 32'h0000_0000;
    chk("order", mem[32'h0000_3000], 32'hA000 + last);
    chk("src end", mem[32'h1000 + a * 16], 32'h2000 + a * 4);
    wr(REG_PRIO_CLR, pri);
  endtask
  // request on channel 9 until the first item lands, then count items moved
  task automatic part(input logic [31:0] s, input logic [31:0] b, input int exp);
    nwr = 0;
    PERIPH_SINGLE <= s; PERIPH_BURST <= b;
    for (int i = 0; i < 300 && nwr == 0; i++) @(posedge CLOCK);
    PERIPH_SINGLE <= 32'h0000_0000; PERIPH_BURST <= 32'h0000_0000;
    repeat (4) @(posedge CLOCK);
    poll(REG_STATUS, 32'h0000_0020);
    chk("items", 32'(nwr), 32'(exp));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge CLOCK);
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    rd(REG_ENA_SET, d); chk("enable reset", d, RST_WORD);
    wr(REG_PRIO_SET, 32'h0000_0005); wr(REG_PRIO_CLR, 32'h0000_0001);
    rd(REG_PRIO_CLR, d); chk("priority", d, 32'h0000_0004);
    wr(REG_PRIO_CLR, 32'h0000_0004);
    wr(REG_ENA_SET, 32'h0000_0030); wr(REG_ENA_CLR, 32'h0000_0010);
    rd(REG_ENA_SET, d); chk("enable", d, 32'h0000_0020);
    wr(REG_ENA_CLR, 32'h0000_0020);
    rd(8'h40, d); chk("unmapped", d, 32'h0000_0000);
    $display("registers done");
    wr(REG_BASE, 32'h0000_1000);
    race(0, 5, 32'h0000_0020, 0);
    race(4, 7, 32'h0000_0090, 7);
    race(2, 6, 32'h0000_0000, 6);
    $display("priority done");
    arm(9, 5, 1, 1);
    part(32'h200, 32'h0, 1);
    chk("count", 32'(mem[32'h1098][13:4]), 32'h3);
    part(32'h0, 32'h200, 2);
    chk("count", 32'(mem[32'h1098][13:4]), 32'h1);
    part(32'h200, 32'h200, 2);
    rd(REG_ENA_SET, d); chk("auto off", d, 32'h0);
    chk("done", 32'(ndone), 32'h1);
    arm(9, 5, 1, 1); wr(REG_BURST_SET, 32'h200);
    part(32'h200, 32'h0, 0);
    part(32'h0, 32'h200, 2);
    wr(REG_BURST_CLR, 32'h200); arm(9, 5, 1, 0);
    part(32'h200, 32'h0, 0);
    rd(REG_ENA_SET, d); chk("stop off", d, 32'h0);
    wr(REG_ALT, 32'h200); mem[32'h1294] = 32'h3000;
    mem[32'h1298] = mem[32'h1098] | 1; wr(REG_ENA_SET, 32'h200);
    part(32'h200, 32'h0, 1);
    $display("requests done");
    final_report();
  end
endmodule
